// File: tb/pm_model.sv
`timescale 1ns/1ps
// Power management side: drives the three pins as plain levels
module pm_model (
	input  wire logic clk,     // System clock
	input  wire logic pd_req,  // Ask for power-down
	input  wire logic cs_req,  // Ask for CPU stop
	input  wire logic ps_req,  // Ask for PCI stop
	output logic      pd_n,    // Power-down pin
	output logic      cstop_n, // CPU stop pin
	output logic      pstop_n  // PCI stop pin
);
	// Pins idle inactive
	initial begin
		pd_n = 1'b1;
		cstop_n = 1'b1;
		pstop_n = 1'b1;
	end
	// Pins move just after the edge, asynchronous to the block
	always @(posedge clk) begin
		pd_n <= #1 !pd_req;
		cstop_n <= #1 !cs_req;
		pstop_n <= #1 !ps_req;
	end
endmodule // pm_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; \
	if ((g) !== (e)) begin miscompares++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module tb_top;
	logic       clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
	logic       pd_req = 1'b0, cs_req = 1'b0, ps_req = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       pd_n, cs_n, ps_n, busy;
	int         miscompares = 0, cmp_count = 0;
	diff_clk_pkg::drive_t cpu_drive [3];
	diff_clk_pkg::drive_t ref_drive;
	// Short names for the expected modes
	localparam diff_clk_pkg::drive_t run_m  = diff_clk_pkg::drv_run;
	localparam diff_clk_pkg::drive_t stop_m = diff_clk_pkg::drv_stop;
	localparam diff_clk_pkg::drive_t pd_m   = diff_clk_pkg::drv_pd;
	localparam diff_clk_pkg::drive_t flt_m  = diff_clk_pkg::drv_float;
	// Clock, 10 ns period
	always #5 clk = ~clk;
	pm_model pm_model_i (.clk(clk), .pd_req(pd_req), .cs_req(cs_req),
		.ps_req(ps_req), .pd_n(pd_n), .cstop_n(cs_n), .pstop_n(ps_n));
	diff_clock_stop_tristate_ctrl #(.NCPU(3), .RESUME_CYC(20))
	diff_clock_stop_tristate_ctrl_i (.clk(clk), .reset(reset),
		.power_down_pin_n(pd_n), .cpu_stop_n(cs_n), .pci_stop_n(ps_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cpu_drive(cpu_drive), .serial_ref_diff_clock_drive(ref_drive),
		.resume_busy(busy));
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask
	// Set pin requests, then give sync and decision time
	task automatic pins(input logic p, input logic c, input logic s);
		@(posedge clk);
		pd_req <= p;
		cs_req <= c;
		ps_req <= s;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic chk_drv(input logic [1:0] c, input logic [1:0] r);
		for (int i = 0; i < 3; i++)
			`CHK("cpu_drive", c, cpu_drive[i])
		`CHK("ref_drive", r, ref_drive)
	endtask
	// Wait out the resume delay under a bound
	task automatic settle();
		for (int n = 0; n < 100 && busy !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		repeat (8) @(posedge clk);
		#1;
		`CHK("busy", 1'b0, busy)
		chk_drv(run_m, run_m);
	endtask
	task automatic t_regs();
		rd_chk(8'h01, 8'h0f);
		rd_chk(8'h02, 8'h00);
		wr_reg(8'h55, 8'hff);
		rd_chk(8'h55, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_driven();
		pins(1'b0, 1'b1, 1'b1);
		chk_drv(stop_m, stop_m);
		pins(1'b1, 1'b1, 1'b1);
		chk_drv(pd_m, pd_m);
		pins(1'b0, 1'b0, 1'b0);
		settle();
		$display("test driven done");
	endtask
	task automatic t_pd_tri();
		wr_reg(8'h02, 8'h02);
		rd_chk(8'h02, 8'h02);
		pins(1'b0, 1'b1, 1'b0);
		chk_drv(stop_m, run_m);
		pins(1'b1, 1'b1, 1'b0);
		chk_drv(flt_m, pd_m);
		pins(1'b0, 1'b0, 1'b0);
		settle();
		$display("test pd tri done");
	endtask
	// Both tri, then stops and a config write during the resume delay
	task automatic t_resume();
		wr_reg(8'h02, 8'hc3);
		pins(1'b0, 1'b1, 1'b1);
		chk_drv(flt_m, flt_m);
		pins(1'b1, 1'b1, 1'b1);
		chk_drv(flt_m, flt_m);
		pins(1'b0, 1'b1, 1'b1);
		`CHK("busy", 1'b1, busy)
		wr_reg(8'h02, 8'h00);
		pins(1'b0, 1'b0, 1'b0);
		// Still inside the window: old bits and stops hold
		chk_drv(flt_m, flt_m);
		settle();
		pins(1'b0, 1'b1, 1'b1);
		chk_drv(stop_m, stop_m);
		pins(1'b0, 1'b0, 1'b0);
		$display("test resume done");
	endtask
	// One-cycle power-down pulse gives only one low sample
	task automatic t_glitch();
		@(posedge clk);
		pd_req <= 1'b1;
		pins(1'b0, 1'b0, 1'b0);
		chk_drv(run_m, run_m);
		$display("test glitch done");
	endtask
	task automatic t_oe();
		wr_reg(8'h01, 8'h06);
		repeat (4) @(posedge clk);
		#1;
		`CHK("cpu0", flt_m, cpu_drive[0])
		`CHK("cpu1", run_m, cpu_drive[1])
		`CHK("ref", flt_m, ref_drive)
		// Free-running pair ignores CPU stop, stoppable one stops
		wr_reg(8'h01, 8'h26);
		pins(1'b0, 1'b1, 1'b0);
		`CHK("cpu0", flt_m, cpu_drive[0])
		`CHK("cpu1", run_m, cpu_drive[1])
		`CHK("cpu2", stop_m, cpu_drive[2])
		pins(1'b0, 1'b0, 1'b0);
		$display("test oe done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_driven();
		t_pd_tri();
		t_resume();
		t_glitch();
		t_oe();
		conclude();
	end
endmodule // tb_top

// File: verilog/diff_clk_consts.svh
// Behaviour
// - Stop and power-down tristate bits of CPU and serial ref: byte 2
// - CPU bits both driven and enabled: CPU pair is never tristated
// - Power-down tristate only: CPU tristated just during power-down
// - Both CPU bits tristate: tristate on power-down, and on CPU stop unless free-running
// - CPU stop release in resume delay takes effect when delay ends
// - Config writes during resume delay apply when the delay ends
// - Serial ref bits both driven and enabled: pair never tristated
// - Both serial ref bits tristate: tristate on PCI stop or power-down
// - PCI stop release in resume delay resumes serial ref after delay
// - Output with enable bit cleared stays tristated regardless
// - Power-down seen low on two consecutive edges before stopping
`ifndef DIFF_CLK_CONSTS_SVH
`define DIFF_CLK_CONSTS_SVH
`define ADDR_BYTE1       8'h01
`define ADDR_BYTE2       8'h02
`define B2_CPU_STOP_TRI  0
`define B2_CPU_PD_TRI    1
`define B2_REF_STOP_TRI  6
`define B2_REF_PD_TRI    7
`define B1_CPU_OE_LO     0
`define B1_REF_OE        3
`define B1_CPU_FREE_LO   4
`define RST_BYTE1        8'h0f
`define RST_BYTE2        8'h00
`define RESUME_US        1800
`define CLK_MHZ          100
`define RESUME_CYC       (`RESUME_US * `CLK_MHZ)
`define PD_CONFIRM       2
`endif

// File: verilog/diff_clk_pkg.sv
package diff_clk_pkg;
	typedef enum logic [1:0] {
		st_run    = 2'b00,
		st_down   = 2'b01,
		st_resume = 2'b10
	} pd_state_t;
	typedef enum logic [1:0] {
		drv_run   = 2'b00,
		drv_stop  = 2'b01,
		drv_pd    = 2'b10,
		drv_float = 2'b11
	} drive_t;
endpackage

// File: verilog/diff_clock_stop_tristate_ctrl.sv
`timescale 1ns/1ps
`include "diff_clk_consts.svh"
// Drive/tristate selection of CPU and serial ref differential pairs
module diff_clock_stop_tristate_ctrl #(
	parameter int NCPU       = 3,
	parameter int RESUME_CYC = `RESUME_CYC
) (
	input  wire logic       clk,              // 100 MHz clock
	input  wire logic       reset,            // Sync reset, high
	input  wire logic       power_down_pin_n, // Power-down, low active
	input  wire logic       cpu_stop_n,       // CPU stop, low active
	input  wire logic       pci_stop_n,       // PCI stop, low active
	input  wire logic [7:0] addr,             // Register address
	input  wire logic [7:0] wdata,            // Write data
	input  wire logic       wr,               // Write strobe
	input  wire logic       rd,               // Read strobe
	output logic      [7:0] rdata,            // Read data, next cycle
	output diff_clk_pkg::drive_t cpu_drive [NCPU], // CPU pair modes
	output diff_clk_pkg::drive_t serial_ref_diff_clock_drive, // Ref mode
	output logic            resume_busy       // Resume delay active
);
	logic [7:0] byte1_r, byte2_r, byte1_eff_r, byte2_eff_r;
	logic [2:0] pins_s;
	logic       pd_lo_s, cpu_stop_s, pci_stop_s;
	logic [1:0] pd_cnt_r;
	logic [31:0] res_cnt_r;
	logic       cpu_stop_eff_r, pci_stop_eff_r;
	diff_clk_pkg::pd_state_t st_r, st_nxt;

	// Pins synchronised before any decision
	pin_sync #(.W(3)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({power_down_pin_n, cpu_stop_n, pci_stop_n}),
		.q     (pins_s)
	);
	assign pd_lo_s    = ~pins_s[2];
	assign cpu_stop_s = ~pins_s[1];
	assign pci_stop_s = ~pins_s[0];

	// Register decode
	wire sel1 = (addr == `ADDR_BYTE1);
	wire sel2 = (addr == `ADDR_BYTE2);
	wire [7:0] rd_mux = sel1 ? byte1_r : sel2 ? byte2_r : 8'h00;

	// Config storage, byte 2 holds tristate bits
	always_ff @(posedge clk) begin
		if (reset) begin
			byte1_r <= `RST_BYTE1;
			byte2_r <= `RST_BYTE2;
			rdata   <= 8'h00;
		end else begin
			if (wr && sel1) byte1_r <= wdata;
			if (wr && sel2) byte2_r <= wdata;
			rdata <= rd ? rd_mux : 8'h00;
		end
	end

	wire pd_seen   = (pd_cnt_r == 2'(`PD_CONFIRM));
	wire res_done  = (res_cnt_r == 32'(RESUME_CYC - 1));

	// Power-down sequencer
	always_comb begin
		st_nxt = st_r;
		case (st_r)
		diff_clk_pkg::st_run: begin
			if (pd_seen) st_nxt = diff_clk_pkg::st_down;
		end
		diff_clk_pkg::st_down: begin
			if (!pd_lo_s) st_nxt = diff_clk_pkg::st_resume;
		end
		diff_clk_pkg::st_resume: begin
			if (pd_lo_s) st_nxt = diff_clk_pkg::st_down;
			else if (res_done) st_nxt = diff_clk_pkg::st_run;
		end
		default:   st_nxt = diff_clk_pkg::st_run;
		endcase
	end

	// Low count, resume timer, state
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r      <= diff_clk_pkg::st_run;
			pd_cnt_r  <= 2'd0;
			res_cnt_r <= 32'd0;
		end else begin
			st_r <= st_nxt;
			pd_cnt_r <= !pd_lo_s ? 2'd0 : pd_seen ? pd_cnt_r : pd_cnt_r + 2'd1;
			res_cnt_r <= (st_r == diff_clk_pkg::st_resume) ?
				res_cnt_r + 32'd1 : 32'd0;
		end
	end

	wire in_pd = (st_r != diff_clk_pkg::st_run);

	// Stops and config frozen in resume window, applied at its end
	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_stop_eff_r <= 1'b0;
			pci_stop_eff_r <= 1'b0;
			byte1_eff_r    <= `RST_BYTE1;
			byte2_eff_r    <= `RST_BYTE2;
		end else if (!in_pd) begin
			cpu_stop_eff_r <= cpu_stop_s;
			pci_stop_eff_r <= pci_stop_s;
			byte1_eff_r    <= byte1_r;
			byte2_eff_r    <= byte2_r;
		end
	end

	wire c_st = byte2_eff_r[`B2_CPU_STOP_TRI];
	wire c_pd = byte2_eff_r[`B2_CPU_PD_TRI];
	wire s_st = byte2_eff_r[`B2_REF_STOP_TRI];
	wire s_pd = byte2_eff_r[`B2_REF_PD_TRI];

	// Per-CPU pair drive mode
	genvar g;
	generate
		for (g = 0; g < NCPU; g++) begin : g_cpu
			wire oe   = byte1_eff_r[`B1_CPU_OE_LO + g];
			wire free = byte1_eff_r[`B1_CPU_FREE_LO + g];
			diff_clk_pkg::drive_t m;
			always_comb begin
				if (!oe) m = diff_clk_pkg::drv_float;
				else if (in_pd)
					m = c_pd ? diff_clk_pkg::drv_float
					         : diff_clk_pkg::drv_pd;
				else if (cpu_stop_eff_r && !free)
					m = c_st ? diff_clk_pkg::drv_float
					         : diff_clk_pkg::drv_stop;
				else m = diff_clk_pkg::drv_run;
			end
			always_ff @(posedge clk) begin
				if (reset) cpu_drive[g] <= diff_clk_pkg::drv_run;
				else cpu_drive[g] <= m;
			end
		end
	endgenerate

	// Serial ref pair drive mode
	diff_clk_pkg::drive_t sm;
	always_comb begin
		if (!byte1_eff_r[`B1_REF_OE])
			sm = diff_clk_pkg::drv_float;
		else if (in_pd)
			sm = s_pd ? diff_clk_pkg::drv_float
			          : diff_clk_pkg::drv_pd;
		else if (pci_stop_eff_r)
			sm = s_st ? diff_clk_pkg::drv_float
			          : diff_clk_pkg::drv_stop;
		else sm = diff_clk_pkg::drv_run;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			serial_ref_diff_clock_drive <= diff_clk_pkg::drv_run;
			resume_busy <= 1'b0;
		end else begin
			serial_ref_diff_clock_drive <= sm;
			resume_busy <= (st_nxt == diff_clk_pkg::st_resume);
		end
	end

	// Checks
	property p_pd_confirm;
		@(posedge clk) disable iff (reset)
		(st_r == diff_clk_pkg::st_run && !pd_seen) |=>
			st_r == diff_clk_pkg::st_run;
	endproperty
	a_pd_confirm: assert property (p_pd_confirm)
		else $error("early stop");

	// Two low samples in a row, starting from the run state
	sequence s_pd_two_low;
		(st_r == diff_clk_pkg::st_run && pd_lo_s) ##1 pd_lo_s;
	endsequence
	property p_pd_enter;
		@(posedge clk) disable iff (reset)
		s_pd_two_low |-> ##2 in_pd;
	endproperty
	a_pd_enter: assert property (p_pd_enter)
		else $error("late stop");

	property p_cpu_never_tri;
		@(posedge clk) disable iff (reset)
		(!c_st && !c_pd && byte1_eff_r[`B1_CPU_OE_LO]) |=>
			cpu_drive[0] != diff_clk_pkg::drv_float;
	endproperty
	a_cpu_never_tri: assert property (p_cpu_never_tri)
		else $error("cpu float");

	property p_ref_never_tri;
		@(posedge clk) disable iff (reset)
		(!s_st && !s_pd && byte1_eff_r[`B1_REF_OE]) |=>
			serial_ref_diff_clock_drive != diff_clk_pkg::drv_float;
	endproperty
	a_ref_never_tri: assert property (p_ref_never_tri)
		else $error("ref float");

	property p_oe_off;
		@(posedge clk) disable iff (reset)
		!byte1_eff_r[`B1_REF_OE] |=>
			serial_ref_diff_clock_drive == diff_clk_pkg::drv_float;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("disabled driven");

	property p_frozen;
		@(posedge clk) disable iff (reset)
		in_pd |=> $stable(byte2_eff_r) && $stable(cpu_stop_eff_r);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("changed in resume");

	property p_pci_frozen;
		@(posedge clk) disable iff (reset)
		in_pd |=> $stable(pci_stop_eff_r);
	endproperty
	a_pci_frozen: assert property (p_pci_frozen)
		else $error("pci moved");

	property p_cpu_pd_tri;
		@(posedge clk) disable iff (reset)
		(in_pd && c_pd && byte1_eff_r[`B1_CPU_OE_LO]) |=>
			cpu_drive[0] == diff_clk_pkg::drv_float;
	endproperty
	a_cpu_pd_tri: assert property (p_cpu_pd_tri)
		else $error("pd not float");

	// Stoppable CPU pair floats on stop when its stop bit says so
	property p_cpu_stop_tri;
		@(posedge clk) disable iff (reset)
		(!in_pd && cpu_stop_eff_r && c_st && byte1_eff_r[`B1_CPU_OE_LO]
			&& !byte1_eff_r[`B1_CPU_FREE_LO]) |=>
			cpu_drive[0] == diff_clk_pkg::drv_float;
	endproperty
	a_cpu_stop_tri: assert property (p_cpu_stop_tri)
		else $error("cpu stop not float");

	property p_ref_stop_tri;
		@(posedge clk) disable iff (reset)
		(!in_pd && pci_stop_eff_r && s_st && byte1_eff_r[`B1_REF_OE]) |=>
			serial_ref_diff_clock_drive == diff_clk_pkg::drv_float;
	endproperty
	a_ref_stop_tri: assert property (p_ref_stop_tri)
		else $error("no float");

	// Serial ref pair floats in power-down when its bit says so
	property p_ref_pd_tri;
		@(posedge clk) disable iff (reset)
		(in_pd && s_pd && byte1_eff_r[`B1_REF_OE]) |=>
			serial_ref_diff_clock_drive == diff_clk_pkg::drv_float;
	endproperty
	a_ref_pd_tri: assert property (p_ref_pd_tri)
		else $error("ref pd not float");
endmodule // diff_clock_stop_tristate_ctrl

// File: verilog/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser per bit
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,   // System clock
	input  wire logic         reset, // Sync reset
	input  wire logic [W-1:0] d,     // Async input
	output logic      [W-1:0] q      // Synchronised output
);
	logic [W-1:0] meta_r;

	// First stage read only by second
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_r <= {W{1'b1}};
			q      <= {W{1'b1}};
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // pin_sync
